// file: hdl/timer_wave.sv
// Timer waveform mode decoder, counter and compare-output pin logic
//
// Contract
// [RL1] Nonzero action field lets waveform take pins
// [RL2] Pin driver needs direction and pin enable
// [RL3] Clear pin enable or zero action: port
// [RL4] Non-PWM match: toggle, drive low, drive high
// [RL5] Fast PWM: clear/set on match, opposite at TOP
// [RL6] PWM action one: toggle A only if top bit
// [RL7] Fast PWM compare equals TOP: only TOP action
// [RL8] Dual-slope: action by count direction at match
// [RL9] Control A bits three and two unused
// [RL10] Four-bit mode from both control registers
// [RL11] Normal and clear-on-match modes: TOP, immediate update
// [RL12] Modes 1-3: phase correct, fixed TOP
// [RL13] Fast PWM modes: update and flag at TOP
// [RL14] Modes 8-11: dual slope, flag at BOTTOM
// [RL15] Dual slope counts zero to TOP and back
// [RL16] Flag set with compare buffer load; modes 1-3, 10 and 11 load the buffer at TOP but set the flag at BOTTOM
// [RL17] Dual slope: BOTTOM or TOP compare gives constant
// [RL18] Pin enables: A low nibble, B high
// [RL19] Reserved mode counts normally, pins disconnected
// [RL20] Software avoids reserved bits, mode, actions
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
module timer_wave (
    input wire logic aclk,
    input wire logic aresetn,
    input wire timer_wave_pkg::axi_req_t axi_req,
    output timer_wave_pkg::axi_rsp_t axi_rsp,
    input wire timer_wave_pkg::pins_in_t pins_in,
    output timer_wave_pkg::pins_out_t pins_out
);
    import timer_wave_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] pin_en;
        logic [15:0] buf_a;
        logic [15:0] buf_b;
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
        logic [15:0] capt;
        logic [15:0] count;
        logic up;
        logic wave_a;
        logic wave_b;
        logic ovf;
        logic [3:0] div;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

    state_t s_q, s_d;

    logic [3:0] mode;
    mode_dec_t dec;
    logic [15:0] top;
    logic [1:0] act_a, act_b;
    logic pwm;
    logic conn_a, conn_b;
    logic [3:0] sel_a, sel_b;

    // Byte-lane merge for 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0])
            r[7:0] = d[7:0];
        if (strb[1])
            r[15:8] = d[15:8];
        return r;
    endfunction : merge16

    // Next waveform level for one channel on a timer tick
    function automatic logic wave_step(input seq_t seq, input logic [1:0] act,
                                       input logic wave, input logic [15:0] cnt,
                                       input logic [15:0] cmp, input logic [15:0] tp,
                                       input logic up, input logic top_bit,
                                       input logic is_a);
        logic w, match, tgl;
        w = wave;
        match = (cnt == cmp);
        tgl = (act == ACT_TOGGLE) && is_a && top_bit && match; // [RL6]
        case (seq)
            SEQ_NORMAL, SEQ_CTC:
                if (match)
                    case (act) // [RL4]
                        ACT_TOGGLE: w = !wave;
                        ACT_CLEAR: w = 1'b0;
                        ACT_SET: w = 1'b1;
                        default: w = wave;
                    endcase
            SEQ_FAST:
                // TOP action first, so a clear or set match at TOP is dropped; a toggle match at TOP still toggles
                if (act[1] && (cnt == tp)) // [RL7]
                    w = (act == ACT_CLEAR); // [RL5]
                else if (act[1] && match)
                    w = (act == ACT_SET); // [RL5]
                else if (tgl)
                    w = !wave; // [RL6]
            SEQ_PC, SEQ_PFC:
                if (act[1] && (cmp == BOTTOM)) // [RL17]
                    w = act[0];
                else if (act[1] && (cmp == tp)) // [RL17]
                    w = !act[0];
                else if (act[1] && match)
                    w = up ? act[0] : !act[0]; // [RL8]
                else if (tgl)
                    w = !wave; // [RL6]
            default: w = wave;
        endcase
        return w;
    endfunction : wave_step

    // Whether a channel's waveform owns its pins
    function automatic logic connected(input logic [1:0] act, input logic is_pwm,
                                       input logic top_bit, input logic is_a,
                                       input logic rsvd);
        logic c;
        c = (act != ACT_OFF) && !rsvd; // [RL1] [RL3] [RL19]
        if (is_pwm && (act == ACT_TOGGLE) && !(top_bit && is_a))
            c = 1'b0; // [RL6]
        return c;
    endfunction : connected

    // Register read mux
    function automatic logic [31:0] read_reg(input state_t s, input logic [7:0] addr,
                                             input logic [3:0] md);
        logic [31:0] r;
        r = '0;
        case (addr)
            OFF_CTRL_A: r[7:0] = s.ctrl_a;
            OFF_CTRL_B: r[7:0] = s.ctrl_b;
            OFF_PIN_EN: r[7:0] = s.pin_en;
            OFF_CMP_A: r[15:0] = s.buf_a;
            OFF_CMP_B: r[15:0] = s.buf_b;
            OFF_CAPT: r[15:0] = s.capt;
            OFF_COUNT: r[15:0] = s.count;
            OFF_STATUS:
            begin
                r[STAT_OVF_BIT] = s.ovf;
                r[STAT_UP_BIT] = s.up;
                r[STAT_WAVE_A_BIT] = s.wave_a;
                r[STAT_WAVE_B_BIT] = s.wave_b;
                r[STAT_MODE_LSB +: 4] = md;
            end
            default: r = '0;
        endcase
        return r;
    endfunction : read_reg

    function automatic logic mapped(input logic [7:0] addr);
        return (addr == OFF_CTRL_A) || (addr == OFF_CTRL_B) || (addr == OFF_PIN_EN)
            || (addr == OFF_CMP_A) || (addr == OFF_CMP_B) || (addr == OFF_CAPT)
            || (addr == OFF_COUNT) || (addr == OFF_STATUS);
    endfunction : mapped

    assign mode = {s_q.ctrl_b[CB_WGM_LSB +: 2], s_q.ctrl_a[CA_WGM_LSB +: 2]}; // [RL10]
    assign dec = decode_mode(mode); // [RL10] [RL11] [RL12] [RL13] [RL14]
    assign top = (dec.top_src == TOP_CMP_A) ? s_q.cmp_a :
                 (dec.top_src == TOP_CAPT) ? s_q.capt : dec.fixed_top;
    assign act_a = s_q.ctrl_a[CA_ACT_A_LSB +: 2];
    assign act_b = s_q.ctrl_a[CA_ACT_B_LSB +: 2];
    assign pwm = (dec.seq == SEQ_FAST) || (dec.seq == SEQ_PC) || (dec.seq == SEQ_PFC);
    assign conn_a = connected(act_a, pwm, mode[3], 1'b1, dec.reserved);
    assign conn_b = connected(act_b, pwm, mode[3], 1'b0, dec.reserved);

    // Pin enables gate each pin; a clear enable leaves port control
    assign sel_a = s_q.pin_en[3:0] & {4{conn_a}}; // [RL18] [RL3]
    assign sel_b = s_q.pin_en[PE_B_LSB +: 4] & {4{conn_b}}; // [RL18] [RL3]
    assign pins_out.out_a = (sel_a & {4{s_q.wave_a}}) | (~sel_a & pins_in.port_a); // [RL1]
    assign pins_out.out_b = (sel_b & {4{s_q.wave_b}}) | (~sel_b & pins_in.port_b); // [RL1]
    // Waveform drives a pin only where direction and enable are both set
    assign pins_out.oe_a = pins_in.dir_a; // [RL2]
    assign pins_out.oe_b = pins_in.dir_b; // [RL2]

    assign axi_rsp.awready = !s_q.aw_got && !s_q.bvalid;
    assign axi_rsp.wready = !s_q.w_got && !s_q.bvalid;
    assign axi_rsp.bvalid = s_q.bvalid;
    assign axi_rsp.bresp = s_q.bresp;
    assign axi_rsp.arready = !s_q.rvalid;
    assign axi_rsp.rvalid = s_q.rvalid;
    assign axi_rsp.rdata = s_q.rdata;
    assign axi_rsp.rresp = s_q.rresp;

    always_comb
    begin
        logic tick, at_top, at_bot, flag_ev, upd_ev;
        tick = 1'b0;
        at_top = 1'b0;
        at_bot = 1'b0;
        flag_ev = 1'b0;
        upd_ev = 1'b0;
        s_d = s_q;

        // Write channel: address and data in either order
        if (axi_req.awvalid && axi_rsp.awready)
        begin
            s_d.aw_got = 1'b1;
            s_d.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && axi_rsp.wready)
        begin
            s_d.w_got = 1'b1;
            s_d.wdata = axi_req.wdata;
            s_d.wstrb = axi_req.wstrb;
        end
        if (s_q.aw_got && s_q.w_got)
        begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = mapped(s_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            if (s_q.wstrb[0])
            begin
                case (s_q.aw_addr)
                    OFF_CTRL_A: s_d.ctrl_a = s_q.wdata[7:0] & CTRL_A_MASK; // [RL9]
                    OFF_CTRL_B: s_d.ctrl_b = s_q.wdata[7:0] & CTRL_B_MASK;
                    OFF_PIN_EN: s_d.pin_en = s_q.wdata[7:0]; // [RL18]
                    OFF_STATUS:
                    begin
                        if (s_q.wdata[STAT_OVF_BIT])
                        begin
                            s_d.ovf = 1'b0;
                        end
                    end
                    default: s_d.pin_en = s_q.pin_en;
                endcase
            end
            case (s_q.aw_addr)
                OFF_CMP_A: s_d.buf_a = merge16(s_q.buf_a, s_q.wdata, s_q.wstrb);
                OFF_CMP_B: s_d.buf_b = merge16(s_q.buf_b, s_q.wdata, s_q.wstrb);
                OFF_CAPT: s_d.capt = merge16(s_q.capt, s_q.wdata, s_q.wstrb);
                default: s_d.capt = s_d.capt;
            endcase
        end
        if (s_q.bvalid && axi_req.bready)
            s_d.bvalid = 1'b0;

        // Read channel
        if (axi_req.arvalid && axi_rsp.arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rdata = read_reg(s_q, axi_req.araddr, mode);
            s_d.rresp = mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_q.rvalid && axi_req.rready)
            s_d.rvalid = 1'b0;

        // Timer clock enable divider
        if (s_q.div == TICK_DIV_M1)
        begin
            s_d.div = TICK_ZERO;
            tick = 1'b1;
        end
        else
        begin
            s_d.div = s_q.div + TICK_ONE;
        end

        if (tick)
        begin
            at_top = (s_q.count == top);
            at_bot = (s_q.count == BOTTOM);
            s_d.wave_a = wave_step(dec.seq, act_a, s_q.wave_a, s_q.count, s_q.cmp_a, top,
                                   s_q.up, mode[3], 1'b1);
            s_d.wave_b = wave_step(dec.seq, act_b, s_q.wave_b, s_q.count, s_q.cmp_b, top,
                                   s_q.up, mode[3], 1'b0);
            case (dec.seq)
                SEQ_PC, SEQ_PFC:
                begin
                    if (s_q.up && (s_q.count >= top)) // [RL15]
                        s_d.up = 1'b0;
                    else if (!s_q.up && at_bot) // [RL15]
                        s_d.up = 1'b1;
                    s_d.count = s_d.up ? s_q.count + ONE : s_q.count - ONE;
                end
                default:
                begin
                    s_d.up = 1'b1;
                    s_d.count = at_top ? BOTTOM : s_q.count + ONE; // [RL11] [RL13]
                end
            endcase
            case (dec.flag_at)
                FLAG_TOP: flag_ev = at_top; // [RL13]
                FLAG_BOTTOM: flag_ev = at_bot; // [RL12] [RL14]
                default: flag_ev = (s_q.count == TOP_MAX); // [RL11]
            endcase
            case (dec.upd)
                UPD_TOP: upd_ev = at_top; // [RL12] [RL13] [RL14]
                UPD_BOTTOM: upd_ev = at_bot; // [RL14]
                default: upd_ev = 1'b0;
            endcase
        end

        // Hardware set wins over a same-cycle software clear
        if (flag_ev)
        begin
            s_d.ovf = 1'b1; // [RL16]
        end
        if (upd_ev)
        begin
            s_d.cmp_a = s_q.buf_a; // [RL16]
            s_d.cmp_b = s_q.buf_b;
        end
        if (dec.upd == UPD_NOW)
        begin
            s_d.cmp_a = s_d.buf_a; // [RL11]
            s_d.cmp_b = s_d.buf_b;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q <= '0;
            s_q.ctrl_a <= RESET_BYTE;
            s_q.ctrl_b <= RESET_BYTE;
            s_q.pin_en <= RESET_BYTE;
            s_q.count <= RESET_WORD;
            s_q.up <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule : timer_wave

// file: hdl/timer_wave_pkg.sv
// Constants, types and mode decoder for the timer waveform block
package timer_wave_pkg;

    // Register byte addresses
    localparam logic [7:0] OFF_CTRL_A = 8'h00;
    localparam logic [7:0] OFF_CTRL_B = 8'h04;
    localparam logic [7:0] OFF_PIN_EN = 8'h08;
    localparam logic [7:0] OFF_CMP_A = 8'h0c;
    localparam logic [7:0] OFF_CMP_B = 8'h10;
    localparam logic [7:0] OFF_CAPT = 8'h14;
    localparam logic [7:0] OFF_COUNT = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1c;

    // Writable bits and reset values
    localparam logic [7:0] CTRL_A_MASK = 8'hf3;
    localparam logic [7:0] CTRL_B_MASK = 8'hdf;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // Field positions
    localparam int CA_ACT_A_LSB = 6;
    localparam int CA_ACT_B_LSB = 4;
    localparam int CA_WGM_LSB = 0;
    localparam int CB_WGM_LSB = 3;
    localparam int PE_B_LSB = 4;
    localparam int STAT_OVF_BIT = 0;
    localparam int STAT_UP_BIT = 1;
    localparam int STAT_WAVE_A_BIT = 2;
    localparam int STAT_WAVE_B_BIT = 3;
    localparam int STAT_MODE_LSB = 4;

    // Counter limits
    localparam logic [15:0] TOP_MAX = 16'hffff;
    localparam logic [15:0] TOP_8BIT = 16'h00ff;
    localparam logic [15:0] TOP_9BIT = 16'h01ff;
    localparam logic [15:0] TOP_10BIT = 16'h03ff;
    localparam logic [15:0] BOTTOM = 16'h0000;
    localparam logic [15:0] ONE = 16'h0001;

    // Timer clock enable: one pulse every TICK_DIV_M1 + 1 clocks
    localparam logic [3:0] TICK_DIV_M1 = 4'h3;
    localparam logic [3:0] TICK_ZERO = 4'h0;
    localparam logic [3:0] TICK_ONE = 4'h1;

    // Output actions
    localparam logic [1:0] ACT_OFF = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {SEQ_NORMAL, SEQ_CTC, SEQ_FAST, SEQ_PC, SEQ_PFC} seq_t;
    typedef enum logic [1:0] {TOP_FIXED, TOP_CMP_A, TOP_CAPT} top_src_t;
    typedef enum logic [1:0] {UPD_NOW, UPD_TOP, UPD_BOTTOM} upd_t;
    typedef enum logic [1:0] {FLAG_MAX, FLAG_TOP, FLAG_BOTTOM} flag_at_t;

    typedef struct packed {
        seq_t seq;
        top_src_t top_src;
        logic [15:0] fixed_top;
        upd_t upd;
        flag_at_t flag_at;
        logic reserved;
    } mode_dec_t;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_t;

    typedef struct packed {
        logic [3:0] dir_a;
        logic [3:0] dir_b;
        logic [3:0] port_a;
        logic [3:0] port_b;
    } pins_in_t;

    typedef struct packed {
        logic [3:0] out_a;
        logic [3:0] oe_a;
        logic [3:0] out_b;
        logic [3:0] oe_b;
    } pins_out_t;

    // Mode table; mode 13 falls back to a normal count
    function automatic mode_dec_t decode_mode(input logic [3:0] m);
        mode_dec_t d;
        d = '{SEQ_NORMAL, TOP_FIXED, TOP_MAX, UPD_NOW, FLAG_MAX, 1'b0};
        case (m)
            4'h0: d = '{SEQ_NORMAL, TOP_FIXED, TOP_MAX, UPD_NOW, FLAG_MAX, 1'b0};
            4'h1: d = '{SEQ_PC, TOP_FIXED, TOP_8BIT, UPD_TOP, FLAG_BOTTOM, 1'b0};
            4'h2: d = '{SEQ_PC, TOP_FIXED, TOP_9BIT, UPD_TOP, FLAG_BOTTOM, 1'b0};
            4'h3: d = '{SEQ_PC, TOP_FIXED, TOP_10BIT, UPD_TOP, FLAG_BOTTOM, 1'b0};
            4'h4: d = '{SEQ_CTC, TOP_CMP_A, TOP_MAX, UPD_NOW, FLAG_MAX, 1'b0};
            4'h5: d = '{SEQ_FAST, TOP_FIXED, TOP_8BIT, UPD_TOP, FLAG_TOP, 1'b0};
            4'h6: d = '{SEQ_FAST, TOP_FIXED, TOP_9BIT, UPD_TOP, FLAG_TOP, 1'b0};
            4'h7: d = '{SEQ_FAST, TOP_FIXED, TOP_10BIT, UPD_TOP, FLAG_TOP, 1'b0};
            4'h8: d = '{SEQ_PFC, TOP_CAPT, TOP_MAX, UPD_BOTTOM, FLAG_BOTTOM, 1'b0};
            4'h9: d = '{SEQ_PFC, TOP_CMP_A, TOP_MAX, UPD_BOTTOM, FLAG_BOTTOM, 1'b0};
            4'ha: d = '{SEQ_PC, TOP_CAPT, TOP_MAX, UPD_TOP, FLAG_BOTTOM, 1'b0};
            4'hb: d = '{SEQ_PC, TOP_CMP_A, TOP_MAX, UPD_TOP, FLAG_BOTTOM, 1'b0};
            4'hc: d = '{SEQ_CTC, TOP_CAPT, TOP_MAX, UPD_NOW, FLAG_MAX, 1'b0};
            4'hd: d = '{SEQ_NORMAL, TOP_FIXED, TOP_MAX, UPD_NOW, FLAG_MAX, 1'b1};
            4'he: d = '{SEQ_FAST, TOP_CAPT, TOP_MAX, UPD_TOP, FLAG_TOP, 1'b0};
            4'hf: d = '{SEQ_FAST, TOP_CMP_A, TOP_MAX, UPD_TOP, FLAG_TOP, 1'b0};
            default: d = '{SEQ_NORMAL, TOP_FIXED, TOP_MAX, UPD_NOW, FLAG_MAX, 1'b1};
        endcase
        return d;
    endfunction : decode_mode

endpackage : timer_wave_pkg

// file: verification/timer_wave_props.sv
// Bus and pin checks for the timer waveform block
module timer_wave_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire timer_wave_pkg::axi_req_t axi_req,
    input wire timer_wave_pkg::axi_rsp_t axi_rsp,
    input wire timer_wave_pkg::pins_in_t pins_in,
    input wire timer_wave_pkg::pins_out_t pins_out
);
    import timer_wave_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_oe_from_dir: assert property (pins_out.oe_a == pins_in.dir_a
        && pins_out.oe_b == pins_in.dir_b) else $error("output enable differs from direction");
    chk_reset_port_pins: assert property (!$past(aresetn) |->
        pins_out.out_a == pins_in.port_a && pins_out.out_b == pins_in.port_b)
        else $error("pins not under port control after reset");
    chk_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("read not answered");
    chk_write_answer: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
        && axi_rsp.wready |-> ##[1:2] axi_rsp.bvalid) else $error("write not answered");
    chk_unmapped_error: assert property (axi_req.arvalid && axi_rsp.arready
        && axi_req.araddr[7:5] != 3'h0 |=> axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0)
        else $error("unmapped read not refused");
    chk_ctrl_free_bits: assert property (axi_req.arvalid && axi_rsp.arready
        && axi_req.araddr == OFF_CTRL_A |=> axi_rsp.rdata[3:2] == 2'h0)
        else $error("free control bits read nonzero");
    chk_bresp_done: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
        else $error("write response not retired");
    chk_rresp_done: assert property (axi_rsp.rvalid && axi_req.rready |=> !axi_rsp.rvalid)
        else $error("read response not retired");
    chk_arready_free: assert property (axi_rsp.arready == !axi_rsp.rvalid)
        else $error("read address ready wrong");
    cov_write: cover property (axi_rsp.bvalid && axi_req.bready);
    cov_slverr: cover property (axi_rsp.rvalid && axi_rsp.rresp == RESP_SLVERR);
    cov_takeover: cover property (pins_out.out_a != pins_in.port_a);
endmodule : timer_wave_props

bind timer_wave timer_wave_props timer_wave_props_i (.aclk(aclk), .aresetn(aresetn),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .pins_in(pins_in), .pins_out(pins_out));

// file: verification/pin_load.sv
// Pad model with pull-ups on every pin
module pin_load (
    input wire timer_wave_pkg::pins_out_t pins_out,
    output logic [3:0] lvl_a,
    output logic [3:0] lvl_b
);
    import timer_wave_pkg::*;
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            lvl_a[i] = pins_out.oe_a[i] ? pins_out.out_a[i] : 1'b1;
            lvl_b[i] = pins_out.oe_b[i] ? pins_out.out_b[i] : 1'b1;
        end
    end
endmodule : pin_load

// file: verification/timer_wave_tb.sv
// Self-checking bench for the timer waveform block
module timer_wave_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import timer_wave_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    axi_req_t req;
    axi_rsp_t rsp;
    pins_in_t pins_drv;
    pins_out_t pins_seen;
    logic [3:0] lvl_a;
    logic [3:0] lvl_b;
    logic [31:0] rd;
    logic [1:0] rr;
    int num_errors = 0;
    int n_checks = 0;
    int hi;
    int rise;
    always #5 aclk = ~aclk;
    timer_wave timer_wave_i (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
        .pins_in(pins_drv), .pins_out(pins_seen));
    pin_load pin_load_i (.pins_out(pins_seen), .lvl_a(lvl_a), .lvl_b(lvl_b));
    task automatic check(input logic [31:0] s, input logic [31:0] e, input string w);
        n_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("BAD %0t %s: %0h not %0h", $time, w, s, e);
        end
    endtask : check
    task automatic near(input int s, input int e, input int t, input string w);
        check((s > e - t && s < e + t) ? e : s, e, w);
    endtask : near
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask : do_reset
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end
        while (!rsp.bvalid);
        rr = rsp.bresp;
    endtask : wr
    task automatic rd_reg(input logic [7:0] a);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end
        while (!rsp.rvalid);
        rd = rsp.rdata;
        rr = rsp.rresp;
    endtask : rd_reg
    task automatic cfg(input logic [1:0] aa, input logic [1:0] ab, input logic [3:0] m,
            input logic [15:0] c, input logic [7:0] pe);
        wr(OFF_CMP_A, {16'h0, c});
        wr(OFF_CMP_B, {16'h0, c});
        wr(OFF_PIN_EN, {24'h0, pe});
        wr(OFF_CTRL_B, {27'h0, m[3:2], 3'h0});
        wr(OFF_CTRL_A, {24'h0, aa, ab, 2'h0, m[1:0]});
    endtask : cfg
    // Settle, then count high cycles and rising edges on pad a0
    task automatic measure(input int s, input int n);
        logic p;
        repeat (s) @(posedge aclk);
        hi = 0;
        rise = 0;
        p = lvl_a[0];
        repeat (n)
        begin
            @(posedge aclk);
            #1;
            if (lvl_a[0] === 1'b1) hi++;
            if (!p && lvl_a[0]) rise++;
            p = lvl_a[0];
        end
    endtask : measure
    task automatic test_regs();
        for (int i = 0; i < 6; i++)
        begin
            rd_reg(8'(i * 4));
            check(rd, 32'h0, "reset value");
        end
        wr(OFF_CTRL_A, 32'hff);
        check({30'h0, rr}, {30'h0, RESP_OKAY}, "okay wr");
        rd_reg(OFF_CTRL_A);
        check(rd, 32'hf3, "ctrl a");
        wr(OFF_CTRL_B, 32'hff);
        rd_reg(OFF_CTRL_B);
        check(rd, 32'hdf, "ctrl b");
        rd_reg(8'h40);
        check({30'h0, rr}, {30'h0, RESP_SLVERR}, "unmapped");
        wr(8'h40, 32'h0);
        check({30'h0, rr}, {30'h0, RESP_SLVERR}, "unmapped wr");
        for (int m = 0; m < 16; m++)
        begin
            wr(OFF_CTRL_B, {27'h0, 2'(m >> 2), 3'h0});
            wr(OFF_CTRL_A, {30'h0, 2'(m)});
            rd_reg(OFF_STATUS);
            check({28'h0, rd[7:4]}, 32'(m), "mode");
        end
        $display("regs done");
    endtask : test_regs
    task automatic test_pins();
        do_reset();
        cfg(2'h3, 2'h3, 4'h4, 16'h40, 8'h5a);
        repeat (300) @(posedge aclk);
        check({28'h0, lvl_a}, 32'ha, "pins a");
        check({28'h0, lvl_b}, 32'h5, "pins b");
        pins_drv.dir_a <= 4'h3;
        repeat (2) @(posedge aclk);
        check({28'h0, lvl_a}, 32'he, "dir gate");
        wr(OFF_PIN_EN, 32'h0);
        check({28'h0, lvl_b}, 32'h0, "pin off");
        pins_drv.dir_a <= 4'hf;
        cfg(2'h1, 2'h0, 4'h4, 16'h40, 8'h0f);
        measure(300, 1040);
        check(rise, 2, "toggle");
        cfg(2'h2, 2'h0, 4'h4, 16'h40, 8'h0f);
        measure(300, 260);
        check(hi, 0, "clear");
        $display("pins done");
    endtask : test_pins
    task automatic test_fast();
        do_reset();
        cfg(2'h2, 2'h0, 4'h5, 16'h40, 8'h0f);
        measure(1100, 1024);
        near(hi, 260, 8, "fast duty");
        cfg(2'h3, 2'h0, 4'h5, 16'h40, 8'h0f);
        measure(1100, 1024);
        near(hi, 764, 8, "fast inv");
        cfg(2'h2, 2'h0, 4'h5, 16'hff, 8'h0f);
        measure(1100, 1024);
        check(hi, 1024, "fast top");
        rd_reg(OFF_STATUS);
        check({31'h0, rd[0]}, 32'h1, "ovf set");
        wr(OFF_STATUS, 32'h1);
        rd_reg(OFF_STATUS);
        check({31'h0, rd[0]}, 32'h0, "ovf clear");
        $display("fast done");
    endtask : test_fast
    task automatic test_phase();
        do_reset();
        cfg(2'h2, 2'h0, 4'h1, 16'h40, 8'h0f);
        measure(2100, 2040);
        near(hi, 512, 12, "pc duty");
        cfg(2'h3, 2'h0, 4'h1, 16'h40, 8'h0f);
        measure(2100, 2040);
        near(hi, 1528, 12, "pc inv");
        cfg(2'h2, 2'h0, 4'h1, 16'h0, 8'h0f);
        measure(2100, 2040);
        check(hi, 0, "pc bottom");
        cfg(2'h2, 2'h0, 4'h1, 16'hff, 8'h0f);
        measure(2100, 2040);
        check(hi, 2040, "pc top");
        $display("phase done");
    endtask : test_phase
    task automatic test_odd();
        do_reset();
        pins_drv.port_a <= 4'hf;
        pins_drv.port_b <= 4'hf;
        cfg(2'h1, 2'h1, 4'h1, 16'h40, 8'hff);
        measure(100, 600);
        check(hi, 600, "pwm act one");
        cfg(2'h1, 2'h1, 4'hb, 16'h40, 8'hff);
        measure(1100, 1100);
        check(32'(rise != 0), 1, "a toggles");
        check({28'h0, lvl_b}, 32'hf, "b off");
        cfg(2'h2, 2'h2, 4'hd, 16'h40, 8'hff);
        measure(100, 400);
        check(hi, 400, "mode 13");
        check({28'h0, lvl_b}, 32'hf, "mode 13 b");
        $display("odd done");
    endtask : test_odd
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    initial
    begin
        req = '0;
        req.bready = 1'b1;
        req.rready = 1'b1;
        pins_drv = '{4'hf, 4'hf, 4'h0, 4'h0};
        do_reset();
        test_regs();
        test_pins();
        test_fast();
        test_phase();
        test_odd();
        print_verdict();
    end
    initial
    begin
        repeat (60000) @(posedge aclk);
        num_errors++;
        print_verdict();
    end
endmodule : timer_wave_tb
